// [core/asp_serial_port.sv]
`timescale 1ns/1ps
// Behaviour
// - Serial port ignored while select high.
// - Output tristated whenever select is high.
// - Input bits captured on clock rise.
// - Output changes only on clock fall.
// - End-of-conversion goes low when result ready and select high.
// - Top shared pin: start input or analog.
// - Other shared pin: negative reference or analog.
// - First byte after select falls is command.
// - Either clock idle level accepted.
// - End-of-conversion high in external clock mode.
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int WIDTH = asp_pkg::RESULT_BITS,
    parameter int DEPTH = asp_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout_o,
    output logic dout_oe,
    output logic eoc_n,
    input wire logic conv_start_n,
    output logic conv_start_pin_en,
    output logic analog_top_en,
    output logic ref_neg_en,
    output logic analog_ref_en,
    output logic [1:0] clock_mode_sel,
    output logic conv_req,
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    input wire logic res_valid,
    output logic res_ready,
    input wire logic [WIDTH-1:0] res_data
);
    import asp_pkg::*;

    initial begin
        if (WIDTH < 1 || WIDTH > 32) begin
            $error("asp_serial_port result width out of range");
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] pins_raw;
    logic [3:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic din_s;
    logic cnv_s;

    assign pins_raw = {cs_n, sclk, din, conv_start_n};

    asp_sync #(.WIDTH(4), .RESET_VAL(4'h9)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign cs_s = pins_s[3];
    assign sclk_s = pins_s[2];
    assign din_s = pins_s[1];
    assign cnv_s = pins_s[0];

    // ****************************************
    // Edge detection
    // ****************************************
    logic cs_q;
    logic sclk_q;
    logic cnv_q;
    logic sel;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cnv_fall;

    // Select level gates every clock edge, so an idle-high clock is harmless outside a frame.
    assign sel = !cs_s;
    assign rise = sel && sclk_s && !sclk_q;
    assign fall = sel && !sclk_s && sclk_q;
    assign cs_fall = cs_q && !cs_s;
    assign cnv_fall = cnv_q && !cnv_s;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            cnv_q <= 1'b1;
        end else begin
            cs_q <= cs_s;
            sclk_q <= sclk_s;
            cnv_q <= cnv_s;
        end
    end

    // ****************************************
    // Frame state and command shifter
    // ****************************************
    asp_state_t state_q;
    asp_state_t state_d;
    logic [7:0] shin_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shin_next;
    logic byte_done;
    logic is_setup;
    logic is_conv;

    assign shin_next = {shin_q[6:0], din_s};
    assign byte_done = rise && (bitcnt_q == 4'(CMD_BITS - 1));
    assign is_setup = (shin_next & SETUP_MASK) == SETUP_CODE;
    assign is_conv = (shin_next & CONV_MASK) == CONV_CODE;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ASP_IDLE: if (cs_fall) state_d = ASP_CMD;
            ASP_CMD: if (byte_done) state_d = ASP_DATA;
            ASP_DATA: state_d = ASP_DATA;
        endcase
        if (!sel) begin
            state_d = ASP_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ASP_IDLE;
            shin_q <= 8'h00;
            bitcnt_q <= 4'h0;
        end else begin
            state_q <= state_d;
            if (cs_fall) begin
                bitcnt_q <= 4'h0;
            end else if (rise) begin
                shin_q <= shin_next;
                bitcnt_q <= (bitcnt_q == 4'(CMD_BITS - 1)) ? 4'h0 : bitcnt_q + 4'h1;
            end
        end
    end

    // ****************************************
    // Command decode and configuration
    // ****************************************
    logic cmd_take;
    logic [1:0] clk_mode_q;
    logic [1:0] ref_mode_q;

    assign cmd_take = (state_q == ASP_CMD) && byte_done;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_mode_q <= CLK_MODE_RESET;
            ref_mode_q <= REF_MODE_RESET;
            cmd_byte <= 8'h00;
            cmd_valid <= 1'b0;
            conv_req <= 1'b0;
            clock_mode_sel <= CLK_MODE_RESET;
            conv_start_pin_en <= 1'b0;
            analog_top_en <= 1'b1;
            ref_neg_en <= 1'b0;
            analog_ref_en <= 1'b1;
        end else begin
            cmd_valid <= cmd_take;
            conv_req <= 1'b0;
            if (cmd_take) begin
                cmd_byte <= shin_next;
                if (is_setup) begin
                    clk_mode_q <= shin_next[CLKSEL_HI:CLKSEL_LO];
                    ref_mode_q <= shin_next[REFSEL_HI:REFSEL_LO];
                end
                if (is_conv && clk_mode_q == CLK_MODE_SERIAL) begin
                    conv_req <= 1'b1;
                end
            end
            // Start pin is honoured only in the two pin-started clock modes.
            if (cnv_fall && conv_start_pin_en) begin
                conv_req <= 1'b1;
            end
            clock_mode_sel <= clk_mode_q;
            conv_start_pin_en <= (clk_mode_q == CLK_MODE_PIN_SCAN) || (clk_mode_q == CLK_MODE_PIN_SINGLE);
            analog_top_en <= !((clk_mode_q == CLK_MODE_PIN_SCAN) || (clk_mode_q == CLK_MODE_PIN_SINGLE));
            ref_neg_en <= (ref_mode_q == REF_MODE_EXT_DIFF);
            analog_ref_en <= (ref_mode_q != REF_MODE_EXT_DIFF);
        end
    end

    // ****************************************
    // Result buffer
    // ****************************************
    logic buf_valid;
    logic buf_ready;
    logic [WIDTH-1:0] buf_data;

    asp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data(res_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // ****************************************
    // Output shifter
    // ****************************************
    logic [WIDTH-1:0] shout_q;
    logic [5:0] outcnt_q;
    logic word_empty;

    assign word_empty = (outcnt_q == 6'h00);
    assign buf_ready = (state_q == ASP_DATA) && fall && word_empty;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shout_q <= '0;
            outcnt_q <= 6'h00;
            dout_o <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= sel;
            if (!sel) begin
                outcnt_q <= 6'h00;
            end else if ((state_q == ASP_DATA) && fall) begin
                // An empty buffer shifts zeros rather than stalling the master's clock.
                if (word_empty) begin
                    dout_o <= buf_valid ? buf_data[WIDTH-1] : 1'b0;
                    shout_q <= buf_valid ? (buf_data << 1) : '0;
                    outcnt_q <= 6'(WIDTH - 1);
                end else begin
                    dout_o <= shout_q[WIDTH-1];
                    shout_q <= shout_q << 1;
                    outcnt_q <= outcnt_q - 6'h01;
                end
            end
        end
    end

    // ****************************************
    // End of conversion flag
    // ****************************************
    // Set wins over clear: a result waiting while deselected at a start-pin fall still shows.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eoc_n <= 1'b1;
        end else if (clk_mode_q == CLK_MODE_EXT) begin
            eoc_n <= 1'b1;
        end else if (buf_valid && !sel) begin
            eoc_n <= 1'b0;
        end else if (cs_fall || cnv_fall) begin
            eoc_n <= 1'b1;
        end
    end
    // Clock edges are found by level change, so either idle level of the serial clock works.
endmodule // asp_serial_port

// [core/asp_pkg.sv]
package asp_pkg;
    // ****************************************
    // Link framing
    // ****************************************
    localparam int CMD_BITS = 8;
    localparam int RESULT_BITS = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Setup byte layout
    // ****************************************
    localparam logic [7:0] SETUP_MASK = 8'hC0;
    localparam logic [7:0] SETUP_CODE = 8'h40;
    localparam int CLKSEL_HI = 5;
    localparam int CLKSEL_LO = 4;
    localparam int REFSEL_HI = 3;
    localparam int REFSEL_LO = 2;
    localparam logic [7:0] CONV_MASK = 8'h80;
    localparam logic [7:0] CONV_CODE = 8'h80;

    // ****************************************
    // Modes and reset values
    // ****************************************
    localparam logic [1:0] CLK_MODE_PIN_SCAN = 2'h0;
    localparam logic [1:0] CLK_MODE_PIN_SINGLE = 2'h1;
    localparam logic [1:0] CLK_MODE_SERIAL = 2'h2;
    localparam logic [1:0] CLK_MODE_EXT = 2'h3;
    localparam logic [1:0] CLK_MODE_RESET = 2'h2;
    localparam logic [1:0] REF_MODE_EXT_DIFF = 2'h3;
    localparam logic [1:0] REF_MODE_RESET = 2'h0;

    typedef enum logic [1:0] {
        ASP_IDLE,
        ASP_CMD,
        ASP_DATA
    } asp_state_t;
endpackage

// [core/asp_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser; only the last stage is visible outside.
module asp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // asp_sync

// [core/asp_fifo.sv]
`timescale 1ns/1ps
module asp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("asp_fifo depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic fetch;
    logic [AW:0] rd_next;

    assign count = wr_q - rd_q;
    // The registered head word counts against the depth, so no more than DEPTH words are ever held.
    assign in_ready = ((count + (AW+1)'(out_valid)) != (AW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Registered read port: the head word is loaded whenever the output slot frees up.
    assign fetch = (count != '0) && (!out_valid || pop);
    assign rd_next = rd_q + (AW+1)'(1);

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + (AW+1)'(1);
            end
            if (fetch) begin
                out_data <= mem[rd_q[AW-1:0]];
                rd_q <= rd_next;
                out_valid <= 1'b1;
            end else if (pop) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // asp_fifo

// [tb/asp_checker.sv]
`timescale 1ns/1ps
// ****
// Port checks.
// ****
module asp_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic eoc_n,
    input wire logic conv_start_pin_en,
    input wire logic analog_top_en,
    input wire logic ref_neg_en,
    input wire logic analog_ref_en,
    input wire logic [1:0] clock_mode_sel,
    input wire logic cmd_valid
);
    import asp_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_oe_off: assert property (cs_n [*5] |-> !dout_oe)
        else $error("dout driven while deselected");
    a_oe_on: assert property (!cs_n [*5] |-> dout_oe)
        else $error("dout idle while selected");
    a_dout_fall: assert property ((sclk && !cs_n) [*6] |-> $stable(dout_o))
        else $error("dout moved without a fall");
    a_cmd_sel: assert property (cmd_valid |-> !$past(cs_n, 6))
        else $error("command while deselected");
    a_cmd_gap: assert property (cmd_valid |=> !cmd_valid [*8])
        else $error("commands too close");
    a_pin_role: assert property ($stable(clock_mode_sel) [*2]
        |-> conv_start_pin_en != clock_mode_sel[1] && analog_top_en == clock_mode_sel[1])
        else $error("top pin role wrong");
    a_ref_role: assert property (ref_neg_en != analog_ref_en)
        else $error("ref pin role wrong");
    a_eoc_ext: assert property ((clock_mode_sel == CLK_MODE_EXT) [*2] |-> eoc_n)
        else $error("eoc low in external mode");
endmodule // asp_checker

bind asp_serial_port asp_checker chk (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .dout_o(dout_o), .dout_oe(dout_oe), .eoc_n(eoc_n), .conv_start_pin_en(conv_start_pin_en),
    .analog_top_en(analog_top_en), .ref_neg_en(ref_neg_en), .analog_ref_en(analog_ref_en),
    .clock_mode_sel(clock_mode_sel), .cmd_valid(cmd_valid));

// [tb/asp_master_model.sv]
`timescale 1ns/1ps
// ****
// Host master; sclk stands at its idle level between frames.
// ****
module asp_master_model (
    output logic cs_n = 1'b1,
    output logic sclk = 1'b0,
    output logic din = 1'b0,
    input wire logic dout_o,
    input wire logic dout_oe,
    output logic [asp_pkg::RESULT_BITS-1:0] word = '0,
    output logic stb = 1'b0
);
    import asp_pkg::*;
    logic cpol = 1'b0;
    task automatic set_pol(logic p);
        cpol = p;
        sclk = p;
    endtask
    // Edges with select high; the port must ignore them.
    task automatic noise(int n);
        repeat (n) begin
            sclk = ~sclk;
            din = 1'($urandom);
            #100;
        end
    endtask
    task automatic frame(logic [7:0] cmd, int words);
        cs_n = 1'b0;
        #200;
        for (int i = 0; i < CMD_BITS + RESULT_BITS * words; i++) begin
            if (cpol) sclk = 1'b0;
            din = (i < CMD_BITS) ? cmd[CMD_BITS-1-i] : 1'($urandom);
            #100;
            sclk = 1'b1;
            #100;
            word = {word[RESULT_BITS-2:0], dout_oe ? dout_o : 1'bx};
            stb = i >= CMD_BITS && (i - CMD_BITS) % RESULT_BITS == RESULT_BITS - 1;
            // The last low-going clock waits for select to rise, so it cannot pop a word that is then lost.
            if (!cpol && i != CMD_BITS + RESULT_BITS * words - 1) sclk = 1'b0;
            #1;
            stb = 1'b0;
        end
        #100;
        cs_n = 1'b1;
        sclk = cpol;
        din = ~din;
    endtask
endmodule // asp_master_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
// ****
// Bench.
// ****
module tb_top;
    import asp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic conv_start_n = 1'b1;
    logic res_valid = 1'b0;
    logic [15:0] res_data = '0;
    logic cs_n, sclk, din, dout_o, dout_oe, eoc_n, conv_req, cmd_valid, res_ready, stb;
    logic [3:0] roles;
    logic [1:0] clock_mode_sel;
    logic [7:0] cmd_byte;
    logic [15:0] word;
    logic [15:0] exp_w[$];
    logic [7:0] exp_c[$];
    int error_cnt = 0;
    int check_count = 0;
    int convs = 0;
    always #12.5 sys_clk = ~sys_clk;
    asp_serial_port dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout_o(dout_o), .dout_oe(dout_oe), .eoc_n(eoc_n), .conv_start_n(conv_start_n),
        .conv_start_pin_en(roles[3]), .analog_top_en(roles[2]), .ref_neg_en(roles[1]),
        .analog_ref_en(roles[0]), .clock_mode_sel(clock_mode_sel), .conv_req(conv_req),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data));
    asp_master_model m (.cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
        .dout_oe(dout_oe), .word(word), .stb(stb));
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic offer();
        res_valid = 1'b1;
        res_data = 16'($urandom);
        if (res_ready) exp_w.push_back(res_data);
        step(1);
    endtask
    task automatic report_and_stop();
        $display("%0d checks, %0d mismatches", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge stb) check("word", exp_w.size() ? 32'(exp_w.pop_front()) : 32'h10000, word);
    always @(posedge sys_clk) begin
        if (conv_req) convs++;
        if (cmd_valid) check("cmd", exp_c.size() ? 32'(exp_c.pop_front()) : 32'h100, cmd_byte);
    end
    initial begin
        void'($urandom(96612));
        step(2);
        rst = 1'b0;
        step(4);
        check("oe", 0, dout_oe);
        check("mode", CLK_MODE_RESET, clock_mode_sel);
        check("roles", 4'h5, roles);
        m.noise(16);
        $display("reset test done");
        repeat (FIFO_DEPTH + 4) offer();
        res_valid = 1'b0;
        check("fill", FIFO_DEPTH, exp_w.size());
        check("eoc", 0, eoc_n);
        exp_w.push_back('0);
        exp_c.push_back(CONV_CODE);
        m.frame(CONV_CODE, FIFO_DEPTH + 1);
        step(4);
        check("convs", 1, convs);
        check("eoc", 1, eoc_n);
        $display("stream test done");
        m.set_pol(1'b1);
        for (int k = 0; k < 4; k++) begin
            logic [7:0] c;
            c = SETUP_CODE | 8'(k << CLKSEL_LO) | (k[0] ? 8'h0C : 8'h00);
            exp_c.push_back(c);
            m.frame(c, 0);
            step(4);
            check("mode", k, clock_mode_sel);
            check("roles", {~k[1], k[1], k[0], ~k[0]}, roles);
        end
        offer();
        res_valid = 1'b0;
        step(6);
        check("eoc", 1, eoc_n);
        $display("mode test done");
        m.set_pol(1'b0);
        exp_c.push_back(SETUP_CODE);
        m.frame(SETUP_CODE, 0);
        step(4);
        check("eoc", 0, eoc_n);
        conv_start_n = 1'b0;
        step(4);
        conv_start_n = 1'b1;
        step(4);
        check("convs", 2, convs);
        exp_c.push_back(SETUP_CODE);
        m.frame(SETUP_CODE, 1);
        step(4);
        check("left", 0, exp_w.size());
        $display("start pin test done");
        report_and_stop();
    end
    // Tests need about 75 us; this bound only catches a hang.
    initial begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
endmodule // tb_top
